// file: design/nrps_map.svh
// Constants for the nonvolatile row program sequencer
`ifndef NRPS_MAP_SVH
`define NRPS_MAP_SVH

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define NRPS_CTL_RESET     16'h0000
`define NRPS_CTL_WMASK     16'h407f
`define NRPS_OP_MSB        5
`define NRPS_OP_LSB        0
`define NRPS_ERASE_BIT     6
`define NRPS_NV_WRITE_ENABLE_BIT      14
`define NRPS_START_BIT     15
`define NRPS_OP_ROW_ERASE  6'h18
`define NRPS_OP_ROW_PROG   6'h04

// ----------------------------------------------------------------
// Unlock keys
// ----------------------------------------------------------------
`define NRPS_KEY_FIRST     8'h55
`define NRPS_KEY_SECOND    8'haa

// ----------------------------------------------------------------
// Row geometry and timing
// ----------------------------------------------------------------
`define NRPS_ROW_WORDS     32
`define NRPS_ROW_MASK      24'hffffc0
`define NRPS_CLK_MHZ       10
`define NRPS_ERASE_TIME_US 2000
`define NRPS_PROG_TIME_US  2000
`define NRPS_ERASE_CYCLES  (`NRPS_ERASE_TIME_US * `NRPS_CLK_MHZ)
`define NRPS_PROG_CYCLES   (`NRPS_PROG_TIME_US * `NRPS_CLK_MHZ)

`endif

// file: design/nrps_pkg.sv
// Types for the nonvolatile row program sequencer
package nrps_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_LOAD,
    ST_PROG
  } nrps_state_e;

  typedef enum logic [1:0] {
    KEY_NONE,
    KEY_HALF,
    KEY_OPEN
  } nrps_key_e;

endpackage

// file: design/nrps_sequencer.sv
// Row erase and row program sequencer for program flash
`timescale 1ns/100ps
`default_nettype none
`include "nrps_map.svh"
module nrps_sequencer #(
  parameter int unsigned ERASE_CYCLES = `NRPS_ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES  = `NRPS_PROG_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Control register write and readback
  input  wire logic        ctrl_wr_i,
  input  wire logic [15:0] ctrl_wdata_i,
  output logic      [15:0] nv_control_reg_o,
  // Unlock key register write
  input  wire logic        key_wr_i,
  input  wire logic [7:0]  key_wdata_i,
  // Any other register write
  input  wire logic        other_wr_i,
  // Table write from the core
  input  wire logic        tblwt_i,
  input  wire logic        tblwt_high_i,
  input  wire logic        tblwt_data_mem_i,
  input  wire logic [23:0] tblwt_addr_i,
  input  wire logic [15:0] tblwt_data_i,
  // Processor stall
  output logic             cpu_stall_o,
  // Flash array side
  output logic             arr_erase_o,
  output logic             arr_prog_o,
  output logic [23:0]      arr_row_o,
  output logic             arr_wr_o,
  output logic [4:0]       arr_widx_o,
  output logic [23:0]      arr_wdata_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nrps_pkg::nrps_state_e state_q, state_d;
  nrps_pkg::nrps_key_e   key_q, key_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0]  capture_addr_upper_q, capture_addr_upper_d;
  logic [15:0] capture_addr_lower_q, capture_addr_lower_d;
  logic [23:0] timer_q, timer_d;
  logic [4:0]  widx_q, widx_d;
  logic        wr_q, wr_d;
  logic [23:0] wdata_q, wdata_d;
  logic [23:0] buf_q [`NRPS_ROW_WORDS];
  logic [4:0]  buf_idx;
  logic        start_req;
  logic        op_erase;
  logic        op_prog;
  logic [5:0]  new_op;
  assign new_op  = ctrl_wdata_i[`NRPS_OP_MSB:`NRPS_OP_LSB];
  assign op_erase = (new_op == `NRPS_OP_ROW_ERASE)
                    && ctrl_wdata_i[`NRPS_ERASE_BIT];
  assign op_prog  = (new_op == `NRPS_OP_ROW_PROG)
                    && !ctrl_wdata_i[`NRPS_ERASE_BIT];
  assign start_req = ctrl_wr_i && ctrl_wdata_i[`NRPS_START_BIT]
                     && (key_q == nrps_pkg::KEY_OPEN)
                     && ctrl_wdata_i[`NRPS_NV_WRITE_ENABLE_BIT]
                     && (op_erase || op_prog)
                     && (state_q == nrps_pkg::ST_IDLE);
  // ----------------------------------------------------------------
  // Unlock key tracking
  // ----------------------------------------------------------------
  always_comb begin
    key_d = nrps_pkg::KEY_NONE;
    if (key_wr_i && key_wdata_i == `NRPS_KEY_FIRST) begin
      key_d = nrps_pkg::KEY_HALF;
    end else if (key_wr_i && key_wdata_i == `NRPS_KEY_SECOND
                 && key_q == nrps_pkg::KEY_HALF) begin
      key_d = nrps_pkg::KEY_OPEN;
    end else if (!key_wr_i && !ctrl_wr_i && !other_wr_i && !tblwt_i) begin
      key_d = key_q;
    end
  end
  // ----------------------------------------------------------------
  // Address capture and row buffer
  // ----------------------------------------------------------------
  always_comb begin
    capture_addr_upper_d = capture_addr_upper_q;
    capture_addr_lower_d = capture_addr_lower_q;
    if (tblwt_i) begin
      capture_addr_upper_d = {1'b0, tblwt_addr_i[22:16]};
      capture_addr_lower_d = {tblwt_addr_i[15:1], 1'b0};
    end
  end
  assign buf_idx = tblwt_addr_i[5:1];
  generate
    for (genvar i = 0; i < `NRPS_ROW_WORDS; i++) begin : g_buf
      logic [23:0] ent_d;
      always_comb begin
        ent_d = buf_q[i];
        if (tblwt_i && buf_idx == 5'(i)) begin
          if (!tblwt_high_i) begin
            ent_d[15:0] = tblwt_data_i;
          end else if (!tblwt_data_mem_i) begin
            ent_d[23:16] = tblwt_data_i[7:0];
          end
          if (tblwt_data_mem_i) begin
            ent_d[23:16] = 8'h00;
          end
        end
      end
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          buf_q[i] <= 24'h000000;
        end else begin
          buf_q[i] <= ent_d;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ctrl_d  = ctrl_q;
    timer_d = timer_q;
    widx_d  = widx_q;
    wr_d    = 1'b0;
    wdata_d = wdata_q;
    case (state_q)
      nrps_pkg::ST_IDLE: begin
        if (ctrl_wr_i) begin
          ctrl_d = ctrl_wdata_i & `NRPS_CTL_WMASK;
        end
        if (start_req) begin
          ctrl_d[`NRPS_START_BIT] = 1'b1;
          widx_d = 5'h00;
          if (op_erase) begin
            state_d = nrps_pkg::ST_ERASE;
            timer_d = 24'(ERASE_CYCLES - 1);
          end else begin
            state_d = nrps_pkg::ST_LOAD;
          end
        end
      end
      nrps_pkg::ST_ERASE, nrps_pkg::ST_PROG: begin
        if (timer_q == 24'h000000) begin
          ctrl_d[`NRPS_START_BIT] = 1'b0;
          state_d = nrps_pkg::ST_IDLE;
        end else begin
          timer_d = timer_q - 24'h000001;
        end
      end
      nrps_pkg::ST_LOAD: begin
        wr_d    = 1'b1;
        wdata_d = buf_q[widx_q];
        widx_d  = widx_q + 5'h01;
        if (widx_q == 5'h1f) begin
          state_d = nrps_pkg::ST_PROG;
          timer_d = 24'(PROG_CYCLES - 1);
        end
      end
      default: begin
        state_d = nrps_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q              <= nrps_pkg::ST_IDLE;
      key_q                <= nrps_pkg::KEY_NONE;
      ctrl_q               <= `NRPS_CTL_RESET;
      capture_addr_upper_q <= 8'h00;
      capture_addr_lower_q <= 16'h0000;
      timer_q              <= 24'h000000;
      widx_q               <= 5'h00;
      wr_q                 <= 1'b0;
      wdata_q              <= 24'h000000;
    end else begin
      state_q              <= state_d;
      key_q                <= key_d;
      ctrl_q               <= ctrl_d;
      capture_addr_upper_q <= capture_addr_upper_d;
      capture_addr_lower_q <= capture_addr_lower_d;
      timer_q              <= timer_d;
      widx_q               <= widx_d;
      wr_q                 <= wr_d;
      wdata_q              <= wdata_d;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // stall while busy
  assign cpu_stall_o      = (state_q != nrps_pkg::ST_IDLE);
  assign nv_control_reg_o = ctrl_q;
  assign arr_erase_o      = (state_q == nrps_pkg::ST_ERASE);
  assign arr_prog_o       = (state_q == nrps_pkg::ST_LOAD)
                            || (state_q == nrps_pkg::ST_PROG);
  assign arr_row_o        = {capture_addr_upper_q, capture_addr_lower_q}
                            & `NRPS_ROW_MASK;
  assign arr_wr_o         = wr_q;
  assign arr_widx_o       = widx_q - 5'h01;
  assign arr_wdata_o      = wdata_q;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb_check @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_quiet;
    !key_wr_i && !ctrl_wr_i && !other_wr_i && !tblwt_i;
  endsequence
  sequence s_unlock;
    key_wr_i && key_wdata_i == `NRPS_KEY_FIRST ##1 s_quiet
    ##1 key_wr_i && key_wdata_i == `NRPS_KEY_SECOND ##1 s_quiet;
  endsequence
  property p_erase_starts;
    s_unlock ##1 ctrl_wr_i && ctrl_wdata_i == 16'hc058 && !cpu_stall_o
    |=> arr_erase_o && cpu_stall_o && nv_control_reg_o[15];
  endproperty
  a_erase_starts: assert property (p_erase_starts)
    else $error("erase did not start after unlock");
  property p_prog_streams;
    s_unlock ##1 ctrl_wr_i && ctrl_wdata_i == 16'hc004 && !cpu_stall_o
    |=> ##1 arr_wr_o[*8] ##0 arr_prog_o;
  endproperty
  a_prog_streams: assert property (p_prog_streams)
    else $error("program did not stream buffer words");
  property p_locked_ignored;
    ctrl_wr_i && ctrl_wdata_i[15] && key_q != nrps_pkg::KEY_OPEN
    && !cpu_stall_o |=> !cpu_stall_o && !nv_control_reg_o[15];
  endproperty
  a_locked_ignored: assert property (p_locked_ignored)
    else $error("start accepted without unlock");
  property p_nv_write_enable_needed;
    ctrl_wr_i && !ctrl_wdata_i[14] && !cpu_stall_o |=> !cpu_stall_o;
  endproperty
  a_nv_write_enable_needed: assert property (p_nv_write_enable_needed)
    else $error("start accepted without write enable");
  property p_stall_tracks_start;
    cpu_stall_o == nv_control_reg_o[15];
  endproperty
  a_stall_tracks_start: assert property (p_stall_tracks_start)
    else $error("stall and start bit disagree");
  property p_capture;
    tblwt_i |=> {capture_addr_upper_q, capture_addr_lower_q}
                == ($past(tblwt_addr_i) & 24'h7ffffe);
  endproperty
  a_capture: assert property (p_capture)
    else $error("table write address not captured");
  property p_capture_hold;
    !tblwt_i |=> $stable(capture_addr_lower_q)
                 && $stable(capture_addr_upper_q);
  endproperty
  a_capture_hold: assert property (p_capture_hold)
    else $error("capture changed without table write");
  property p_data_mem_low;
    tblwt_i && tblwt_data_mem_i
    |=> buf_q[$past(buf_idx)][23:16] == 8'h00;
  endproperty
  a_data_mem_low: assert property (p_data_mem_low)
    else $error("data memory word kept an upper byte");
  property p_erase_ends;
    arr_erase_o && timer_q == 24'h000000
    |=> !cpu_stall_o && !nv_control_reg_o[15];
  endproperty
  a_erase_ends: assert property (p_erase_ends)
    else $error("erase end did not release stall");
endmodule

`default_nettype wire

// file: verification/tb_nrps_sequencer.sv
// Self-checking testbench for the row erase and row program sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_nrps_sequencer;

  // ----------------------------------------------------------------
  // Clock, reset and stimulus
  // ----------------------------------------------------------------
  localparam int unsigned ERASE_N = 4;
  localparam int unsigned PROG_N  = 4;

  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ctrl_wr_i = 1'b0;
  logic [15:0] ctrl_wdata_i = 16'h0000;
  logic [15:0] nv_control_reg_o;
  logic        key_wr_i = 1'b0;
  logic [7:0]  key_wdata_i = 8'h00;
  logic        other_wr_i = 1'b0;
  logic        tblwt_i = 1'b0;
  logic        tblwt_high_i = 1'b0;
  logic        tblwt_data_mem_i = 1'b0;
  logic [23:0] tblwt_addr_i = 24'h000000;
  logic [15:0] tblwt_data_i = 16'h0000;
  logic        cpu_stall_o;
  logic        arr_erase_o;
  logic        arr_prog_o;
  logic [23:0] arr_row_o;
  logic        arr_wr_o;
  logic [4:0]  arr_widx_o;
  logic [23:0] arr_wdata_o;
  logic [23:0] exp_buf [32];
  int          mismatches = 0;
  int          checks_done = 0;

  always #50 core_clk_i = ~core_clk_i;

  nrps_sequencer #(
    .ERASE_CYCLES (ERASE_N),
    .PROG_CYCLES  (PROG_N)
  ) i_dut (
    .core_clk_i       (core_clk_i),
    .rst_i            (rst_i),
    .ctrl_wr_i        (ctrl_wr_i),
    .ctrl_wdata_i     (ctrl_wdata_i),
    .nv_control_reg_o (nv_control_reg_o),
    .key_wr_i         (key_wr_i),
    .key_wdata_i      (key_wdata_i),
    .other_wr_i       (other_wr_i),
    .tblwt_i          (tblwt_i),
    .tblwt_high_i     (tblwt_high_i),
    .tblwt_data_mem_i (tblwt_data_mem_i),
    .tblwt_addr_i     (tblwt_addr_i),
    .tblwt_data_i     (tblwt_data_i),
    .cpu_stall_o      (cpu_stall_o),
    .arr_erase_o      (arr_erase_o),
    .arr_prog_o       (arr_prog_o),
    .arr_row_o        (arr_row_o),
    .arr_wr_o         (arr_wr_o),
    .arr_widx_o       (arr_widx_o),
    .arr_wdata_o      (arr_wdata_o)
  );

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_ctrl(input logic [15:0] d);
    @(negedge core_clk_i);
    ctrl_wr_i    = 1'b1;
    ctrl_wdata_i = d;
    @(negedge core_clk_i);
    ctrl_wr_i    = 1'b0;
  endtask

  task automatic wr_key(input logic [7:0] k);
    @(negedge core_clk_i);
    key_wr_i    = 1'b1;
    key_wdata_i = k;
    @(negedge core_clk_i);
    key_wr_i    = 1'b0;
  endtask

  task automatic wr_other();
    @(negedge core_clk_i);
    other_wr_i = 1'b1;
    @(negedge core_clk_i);
    other_wr_i = 1'b0;
  endtask

  task automatic wr_tbl(input logic hi, input logic dm,
                        input logic [23:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    tblwt_i          = 1'b1;
    tblwt_high_i     = hi;
    tblwt_data_mem_i = dm;
    tblwt_addr_i     = a;
    tblwt_data_i     = d;
    @(negedge core_clk_i);
    tblwt_i          = 1'b0;
  endtask

  task automatic unlock();
    wr_key(8'h55);
    wr_key(8'haa);
  endtask

  task automatic refused(input logic [15:0] cw);
    wr_ctrl(cw);
    check("stall", 32'h0, 32'(cpu_stall_o));
    check("ctrl", 32'(cw & 16'h407f), 32'(nv_control_reg_o));
  endtask

  task automatic run_op(input logic [15:0] cw, input logic er,
                        input logic [23:0] row, input int exp_n);
    int n;
    int w;
    n = 0;
    w = 0;
    unlock();
    wr_ctrl(cw);
    check("busy ctrl", 32'(cw), 32'(nv_control_reg_o));
    check("erase lvl", 32'(er), 32'(arr_erase_o));
    check("prog lvl", 32'(!er), 32'(arr_prog_o));
    check("row", 32'(row), 32'(arr_row_o));
    while (cpu_stall_o === 1'b1 && n < 200) begin
      if (arr_wr_o === 1'b1) begin
        check("widx", 32'(w), 32'(arr_widx_o));
        check("wdata", 32'(exp_buf[w[4:0]]), 32'(arr_wdata_o));
        w++;
      end
      n++;
      @(negedge core_clk_i);
    end
    check("stall len", 32'(exp_n), 32'(n));
    check("words", er ? 32'h0 : 32'h20, 32'(w));
    check("done ctrl", 32'(cw & 16'h407f), 32'(nv_control_reg_o));
    check("idle", 32'h0, 32'({arr_erase_o, arr_prog_o}));
  endtask

  task automatic finish_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    check("rst ctrl", 32'h0, 32'(nv_control_reg_o));
    check("rst outs", 32'h0, 32'({cpu_stall_o, arr_erase_o,
                                  arr_prog_o, arr_wr_o, arr_row_o}));
    refused(16'hc058);
    wr_key(8'h55);
    wr_other();
    wr_key(8'haa);
    refused(16'hc058);
    wr_key(8'haa);
    wr_key(8'h55);
    refused(16'hc058);
    unlock();
    refused(16'h8058);
    unlock();
    refused(16'hc018);
    unlock();
    refused(16'hc044);
    unlock();
    refused(16'hc03f);
    unlock();
    wr_tbl(1'b0, 1'b0, 24'h000000, 16'h0000);
    refused(16'hc058);
    wr_tbl(1'b0, 1'b0, 24'h812347, 16'h1234);
    run_op(16'hc058, 1'b1, 24'h012340, ERASE_N);
    for (int i = 0; i < 32; i++) begin
      exp_buf[i] = {8'h80 + 8'(i), 16'h1000 + 16'(i)};
      wr_tbl(1'b0, 1'b0, 24'h851240 + 24'(2 * i), exp_buf[i][15:0]);
      wr_tbl(1'b1, 1'b0, 24'h851240 + 24'(2 * i), {8'h00, exp_buf[i][23:16]});
    end
    exp_buf[0] = 24'h00beef;
    wr_tbl(1'b0, 1'b1, 24'h851240, 16'hbeef);
    wr_tbl(1'b1, 1'b1, 24'h851240, 16'h0077);
    run_op(16'hc004, 1'b0, 24'h051240, 32 + PROG_N);
    finish_test();
  end

endmodule

`default_nettype wire
